// [rtl/irq_bank_pkg.sv]
// Purpose: Shared constants and carriers for the interrupt enable and
//          priority register bank.
// Assumes: 8-bit special-function register space, one system clock.
// Notes:   Offsets are byte addresses within the register space.

package irq_bank_pkg;

   // Register addresses in the special-function register space.
   localparam logic [7:0] base_priority_levels_addr = 8'hb8;
   localparam logic [7:0] extended_enable_one_addr = 8'he6;
   localparam logic [7:0] extended_enable_two_addr = 8'he7;
   localparam logic [7:0] extended_priority_one_addr = 8'hf3;

   // Values after reset of the stored fields, and the value of unmapped reads.
   localparam logic [6:0] base_priority_levels_reset = 7'h00;
   localparam logic [5:0] extended_enable_one_reset = 6'h00;
   localparam logic [1:0] extended_enable_two_reset = 2'h0;
   localparam logic [5:0] extended_priority_one_reset = 6'h00;
   localparam logic [7:0] unmapped_read_value = 8'h00;

   // Field positions in the first extended enable register.
   localparam int two_wire_irq_mask_pos = 0;
   localparam int pin_change_irq_mask_pos = 1;
   localparam int window_compare_irq_mask_pos = 2;
   localparam int counter_array_irq_mask_pos = 3;
   localparam int conversion_done_irq_mask_pos = 4;
   localparam int comparator_irq_mask_pos = 5;

   // Field positions in the second extended enable register.
   localparam int touch_done_irq_mask_pos = 0;
   localparam int touch_threshold_irq_mask_pos = 1;

   // Vector numbers of the sources; 13 and 14 are reserved.
   localparam int vector_count = 17;
   localparam int vector_width = 5;
   localparam int first_extended_vector = 7;
   localparam int touch_done_vector = 15;
   localparam int touch_threshold_vector = 16;

   // One access of the core to the register space.
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_access_type;

   // Pending flags from the peripherals, same clock domain.
   typedef struct packed {
      logic touch_threshold_flag;
      logic touch_done_flag;
      logic comparator_rise_flag;
      logic comparator_fall_flag;
      logic counter_array;
      logic conversion_done_flag;
      logic window_compare_flag;
      logic pin_change;
      logic two_wire;
      logic [6:0] classic;
   } source_flags_type;

endpackage : irq_bank_pkg

// [rtl/irq_enable_priority_bank.sv]
// Purpose: Enable and priority register bank with a two-level request
//          resolver that feeds the processor core.
// Assumes: Flags and the core interface run on clock_i; the global gate
//          and the seven classic enables come from the core's enable
//          register, which lives outside this bank.
// Notes:   Read data appears one cycle after the read strobe.
//          Unmapped addresses read as zero and ignore writes.
//          The touch sources have no level register here and stay low.

`timescale 1ns/1ps
`default_nettype none

module irq_enable_priority_bank (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire irq_bank_pkg::sfr_access_type sfr_i,
   output logic [7:0] sfr_rdata_o,
   input wire irq_bank_pkg::source_flags_type flags_i,
   input wire logic global_irq_gate_i,
   input wire logic [6:0] classic_enable_i,
   output logic irq_req_o,
   output logic [irq_bank_pkg::vector_width-1:0] irq_vector_o,
   output logic irq_high_o,
   input wire logic irq_ack_i,
   input wire logic irq_return_i
);

   // Vector count and index width follow the package so the resolver
   // and the vector output stay in step.
   localparam int nv = irq_bank_pkg::vector_count;
   localparam int vw = irq_bank_pkg::vector_width;

   // Stored fields hold only the writable bits; fixed bits are
   // supplied at read time, so they can never be disturbed.
   logic [6:0] base_priority_levels;
   logic [5:0] extended_enable_one;
   logic [1:0] extended_enable_two;
   logic [5:0] extended_priority_one;
   // Service flags record which level the core is currently serving.
   logic in_service_high;
   logic in_service_low;

   // Address decode of the core's accesses.
   // Each register has one address, so at most one hit is active.
   wire hit_base = sfr_i.addr == irq_bank_pkg::base_priority_levels_addr;
   wire hit_en1 = sfr_i.addr == irq_bank_pkg::extended_enable_one_addr;
   wire hit_en2 = sfr_i.addr == irq_bank_pkg::extended_enable_two_addr;
   wire hit_pri1 = sfr_i.addr == irq_bank_pkg::extended_priority_one_addr;

   // Read multiplexer; unmapped addresses read as zero.
   // A stray read of an unmapped address falls through to a fixed
   // value, so it never returns stale data.
   wire [7:0] base_read = {1'b1, base_priority_levels};
   wire [7:0] en1_read = {2'b00, extended_enable_one};
   wire [7:0] en2_read = {6'b000000, extended_enable_two};
   wire [7:0] pri1_read = {2'b00, extended_priority_one};
   wire [7:0] read_value = hit_base ? base_read :
                           hit_en1 ? en1_read :
                           hit_en2 ? en2_read :
                           hit_pri1 ? pri1_read :
                           irq_bank_pkg::unmapped_read_value;

   // Register writes; the top base bit and reserved bits are not stored.
   // A write to an unmapped address changes nothing.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         base_priority_levels <= irq_bank_pkg::base_priority_levels_reset;
         extended_enable_one <= irq_bank_pkg::extended_enable_one_reset;
         extended_enable_two <= irq_bank_pkg::extended_enable_two_reset;
         extended_priority_one <= irq_bank_pkg::extended_priority_one_reset;
      end else if (sfr_i.write) begin
         if (hit_base) base_priority_levels <= sfr_i.wdata[6:0];
         if (hit_en1) extended_enable_one <= sfr_i.wdata[5:0];
         if (hit_en2) extended_enable_two <= sfr_i.wdata[1:0];
         if (hit_pri1) extended_priority_one <= sfr_i.wdata[5:0];
      end
   end

   // Read data is registered on the read strobe.
   // Holding the data between strobes lets the core take it later; a
   // read and a write in one cycle return the old contents.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_i.read) begin
         sfr_rdata_o <= read_value;
      end
   end

   // Masked requests per vector number.
   // Each source is ANDed with its own enable bit; the global gate is
   // applied afterwards so that it overrides every individual mask.
   wire [nv-1:0] masked_req;
   assign masked_req[6:0] = flags_i.classic & classic_enable_i;
   assign masked_req[7] = flags_i.two_wire &
      extended_enable_one[irq_bank_pkg::two_wire_irq_mask_pos];
   assign masked_req[8] = flags_i.pin_change &
      extended_enable_one[irq_bank_pkg::pin_change_irq_mask_pos];
   assign masked_req[9] = flags_i.window_compare_flag &
      extended_enable_one[irq_bank_pkg::window_compare_irq_mask_pos];
   assign masked_req[10] = flags_i.conversion_done_flag &
      extended_enable_one[irq_bank_pkg::conversion_done_irq_mask_pos];
   assign masked_req[11] = flags_i.counter_array &
      extended_enable_one[irq_bank_pkg::counter_array_irq_mask_pos];
   assign masked_req[12] =
      (flags_i.comparator_rise_flag | flags_i.comparator_fall_flag) &
      extended_enable_one[irq_bank_pkg::comparator_irq_mask_pos];
   // Reserved vectors are tied off so that they can never win.
   assign masked_req[14:13] = 2'b00; // Reserved vectors never request.
   assign masked_req[irq_bank_pkg::touch_done_vector] =
      flags_i.touch_done_flag &
      extended_enable_two[irq_bank_pkg::touch_done_irq_mask_pos];
   assign masked_req[irq_bank_pkg::touch_threshold_vector] =
      flags_i.touch_threshold_flag &
      extended_enable_two[irq_bank_pkg::touch_threshold_irq_mask_pos];

   // Level of each vector; the touch sources sit at low level here.
   // A one in a level bit marks the source as high level.
   wire [nv-1:0] level;
   assign level[6:0] = base_priority_levels;
   assign level[12:7] = extended_priority_one;
   assign level[16:13] = 4'h0;

   // The gate acts last so that no mask setting can bypass it.
   // global gate override
   wire [nv-1:0] gated_req = global_irq_gate_i ? masked_req : '0;

   // High requests are held back only by a high service in progress,
   // low requests by any service, so nesting is at most two deep.
   // preemption by level
   wire [nv-1:0] eligible_high = gated_req & level &
      {nv{~in_service_high}};
   wire [nv-1:0] eligible_low = gated_req & ~level &
      {nv{~in_service_high & ~in_service_low}};

   // Returns the lowest set index of a request vector.
   // The loop runs from the top down, so the last hit, which is the
   // lowest index, is the one kept.
   function automatic logic [vw-1:0] lowest_set(input logic [nv-1:0] v);
      logic [vw-1:0] idx;
      idx = '0;
      for (int i = nv - 1; i >= 0; i--) begin
         if (v[i]) idx = vw'(i);
      end
      return idx;
   endfunction : lowest_set

   wire any_high = |eligible_high;
   wire any_low = |eligible_low;
   wire [vw-1:0] pick_vector = any_high ? lowest_set(eligible_high) :
                               lowest_set(eligible_low);
   // A taken request is withdrawn for one cycle while service updates.
   // Without this gap the core could take the same request twice before
   // its service flag is visible here.
   wire next_req = (any_high | any_low) & ~(irq_ack_i & irq_req_o);

   // Request outputs come from flip-flops.
   // Registering them keeps the core's timing path short at the cost of
   // one cycle of request latency.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_req_o <= 1'b0;
         irq_vector_o <= '0;
         irq_high_o <= 1'b0;
      end else begin
         irq_req_o <= next_req;
         irq_vector_o <= pick_vector;
         irq_high_o <= any_high;
      end
   end

   // Service levels: set on acceptance, cleared innermost first on return.
   // A return with no service active changes nothing; an ack and a
   // return in one cycle clear the inner level and record the new one.
   wire ack_taken = irq_ack_i & irq_req_o;
   wire next_high = (in_service_high & ~irq_return_i) |
                    (ack_taken & irq_high_o);
   wire next_low = (in_service_low &
                    ~(irq_return_i & ~in_service_high)) |
                   (ack_taken & ~irq_high_o);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         in_service_high <= 1'b0;
         in_service_low <= 1'b0;
      end else begin
         in_service_high <= next_high;
         in_service_low <= next_low;
      end
   end

endmodule : irq_enable_priority_bank

`default_nettype wire

// [bench/irq_bank_monitor.sv]
// Purpose: Port assertions for the interrupt enable and priority bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the bank by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module irq_bank_monitor (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire irq_bank_pkg::sfr_access_type sfr_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire irq_bank_pkg::source_flags_type flags_i,
   input wire logic global_irq_gate_i,
   input wire logic [6:0] classic_enable_i,
   input wire logic irq_req_o,
   input wire logic [irq_bank_pkg::vector_width-1:0] irq_vector_o,
   input wire logic irq_high_o,
   input wire logic irq_ack_i,
   input wire logic irq_return_i
);
   // All checks share the bank clock and its reset.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   top_bit_a: assert property (
      sfr_i.read && sfr_i.addr == 8'hb8 |=> sfr_rdata_o[7])
      else $error("base top bit read low");
   upper_zero_a: assert property (
      sfr_i.read && sfr_i.addr == 8'he7 |=> sfr_rdata_o[7:2] == 6'h00)
      else $error("second enable upper bits not zero");
   gate_off_a: assert property (
      !global_irq_gate_i |=> !irq_req_o)
      else $error("request while global gate off");
   cmp_cause_a: assert property (
      irq_req_o && irq_vector_o == 5'h0c |->
      $past(flags_i.comparator_rise_flag || flags_i.comparator_fall_flag))
      else $error("comparator request without flag");
   req_cause_a: assert property (
      irq_req_o |-> $past(global_irq_gate_i))
      else $error("request without prior gate");
   ack_gap_a: assert property (
      irq_ack_i && irq_req_o |=> !irq_req_o)
      else $error("request held after ack");
   vec_legal_a: assert property (
      irq_req_o |-> irq_vector_o < 5'h11 && irq_vector_o != 5'h0d
      && irq_vector_o != 5'h0e) else $error("illegal vector");
   touch_low_a: assert property (
      irq_req_o && irq_vector_o >= 5'h0f |-> !irq_high_o)
      else $error("touch request at high level");
   pin_cause_a: assert property (
      irq_req_o && irq_vector_o == 5'h08 |-> $past(flags_i.pin_change))
      else $error("port-match request without event");
   bus_cause_a: assert property (
      irq_req_o && irq_vector_o == 5'h07 |-> $past(flags_i.two_wire))
      else $error("two-wire request without flag");
   touch_over_a: assert property (
      irq_req_o && irq_vector_o == 5'h10 |->
      $past(flags_i.touch_threshold_flag))
      else $error("touch threshold request without flag");
   touch_done_a: assert property (
      irq_req_o && irq_vector_o == 5'h0f |->
      $past(flags_i.touch_done_flag))
      else $error("touch done request without flag");
endmodule : irq_bank_monitor
bind irq_enable_priority_bank irq_bank_monitor u_mon (
   .clock_i(clock_i), .rst_i(rst_i), .sfr_i(sfr_i),
   .sfr_rdata_o(sfr_rdata_o), .flags_i(flags_i),
   .global_irq_gate_i(global_irq_gate_i),
   .classic_enable_i(classic_enable_i), .irq_req_o(irq_req_o),
   .irq_vector_o(irq_vector_o), .irq_high_o(irq_high_o),
   .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i));
`default_nettype wire

// [bench/core_model.sv]
// Purpose: Core model that takes requests and ends service routines.
// Assumes: One routine at a time; ack only while a request stands.
// Notes:   The return comes wait_i plus one cycles after the ack.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic auto_i,
   input wire logic [3:0] wait_i,
   input wire logic irq_req_i,
   output logic ack_o,
   output logic ret_o
);
   logic busy;
   logic [3:0] left;
   // Acks one request when idle, then counts down to the return pulse.
   always_ff @(posedge clock_i) begin
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      if (rst_i) begin
         busy <= 1'b0;
      end else if (!busy) begin
         busy <= auto_i && irq_req_i && !ack_o;
         ack_o <= auto_i && irq_req_i && !ack_o;
         left <= wait_i;
      end else begin
         left <= left - 4'h1;
         busy <= left != 4'h0;
         ret_o <= left == 4'h0;
      end
   end
endmodule : core_model
`default_nettype wire

// [bench/irq_enable_priority_bank_tb.sv]
// Purpose: Self-checking bench of the interrupt enable and priority bank.
// Assumes: The core model acks requests while auto is set.
// Notes:   Expected values come from the register map.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module irq_enable_priority_bank_tb;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   irq_bank_pkg::sfr_access_type sfr = '0;
   irq_bank_pkg::source_flags_type flags = '0;
   logic gate = 1'b0;
   logic auto = 1'b0;
   logic [6:0] cen = 7'h00;
   logic [7:0] rdata;
   logic req, high, ack, ret;
   logic [4:0] vec;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] en[9] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h08, 8'h20, 8'h20,
                         8'h01, 8'h02};
   logic [4:0] vtab[9] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c,
                           5'h0c, 5'h0f, 5'h10};
   irq_enable_priority_bank u_dut (.clock_i(clock_i), .rst_i(rst_i),
      .sfr_i(sfr), .sfr_rdata_o(rdata), .flags_i(flags),
      .global_irq_gate_i(gate), .classic_enable_i(cen), .irq_req_o(req),
      .irq_vector_o(vec), .irq_high_o(high), .irq_ack_i(ack),
      .irq_return_i(ret));
   core_model u_core (.clock_i(clock_i), .rst_i(rst_i), .auto_i(auto),
      .wait_i(4'hf), .irq_req_i(req), .ack_o(ack), .ret_o(ret));
   // Clock and a cycle ceiling against hangs.
   initial forever #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      sfr <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge clock_i);
      sfr.write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i);
      sfr <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock_i);
      sfr.read <= 1'b0;
      #1 `CHK("read data", e, rdata)
   endtask : rd
   task automatic look(input logic r, input logic [4:0] v, input logic h);
      @(posedge clock_i);
      #1 `CHK("request", r, req)
      if (r) `CHK("vector and level", {v, h}, {vec, high})
   endtask : look
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // Register values, reserved bits, then masks, then priority order.
   initial begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(8'hb8, 8'h80);
      rd(8'he6, 8'h00);
      rd(8'he7, 8'h00);
      rd(8'hf3, 8'h00);
      wr(8'hb8, 8'h7f);
      rd(8'hb8, 8'hff);
      wr(8'hb8, 8'h00);
      rd(8'hb8, 8'h80);
      wr(8'he7, 8'hff);
      rd(8'he7, 8'h03);
      wr(8'hf3, 8'hff);
      rd(8'hf3, 8'h3f);
      wr(8'he6, 8'hff);
      rd(8'he6, 8'h3f);
      wr(8'h55, 8'ha5);
      rd(8'h55, 8'h00);
      $display("end of register test");
      @(posedge clock_i);
      gate <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         wr(8'he6, 8'h00);
         wr(8'he7, 8'h00);
         flags <= irq_bank_pkg::source_flags_type'(16'h0001 << (i + 7));
         look(1'b0, 5'h00, 1'b0);
         wr(i < 7 ? 8'he6 : 8'he7, en[i]);
         look(1'b1, vtab[i], i < 7);
      end
      @(posedge clock_i);
      gate <= 1'b0;
      look(1'b0, 5'h00, 1'b0);
      look(1'b0, 5'h00, 1'b0);
      $display("end of mask test");
      @(posedge clock_i);
      gate <= 1'b1;
      cen <= 7'h7f;
      wr(8'he7, 8'h00);
      wr(8'hb8, 8'h20);
      flags <= irq_bank_pkg::source_flags_type'(16'h0022);
      look(1'b1, 5'h05, 1'b1);
      wr(8'hb8, 8'h00);
      look(1'b1, 5'h01, 1'b0);
      @(posedge clock_i);
      auto <= 1'b1;
      repeat (3) @(posedge clock_i);
      look(1'b0, 5'h00, 1'b0);
      wr(8'hb8, 8'h20);
      look(1'b1, 5'h05, 1'b1);
      wr(8'hb8, 8'h22);
      repeat (10) @(posedge clock_i);
      look(1'b0, 5'h00, 1'b0);
      repeat (15) @(posedge clock_i);
      look(1'b1, 5'h01, 1'b1);
      $display("end of priority test");
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      look(1'b1, 5'h01, 1'b0);
      rd(8'hb8, 8'h80);
      rd(8'hf3, 8'h00);
      $display("end of reset test");
      wrap_up();
   end
endmodule : irq_enable_priority_bank_tb
`default_nettype wire
